// ===== core/smspi_defs.vh
`ifndef SMSPI_DEFS_VH
`define SMSPI_DEFS_VH
// Opcodes
`define SMSPI_OP_SET_LATCH   8'h06
`define SMSPI_OP_CLR_LATCH   8'h04
`define SMSPI_OP_STAT_READ   8'h05
`define SMSPI_OP_STAT_WRITE  8'h01
`define SMSPI_OP_DATA_READ   8'h03
`define SMSPI_OP_DATA_WRITE  8'h02
`define SMSPI_OP_SLEEP       8'hB9
`define SMSPI_OP_WAKE        8'hAB
// Status byte layout
`define SMSPI_ST_LOCK        7
`define SMSPI_ST_PSEL_HI     3
`define SMSPI_ST_PSEL_LO     2
`define SMSPI_ST_LATCH       1
`define SMSPI_ST_RESET       8'h00
// Bits of the status byte a status write may change (latch excluded)
`define SMSPI_ST_WMASK       8'hFD
// Array geometry
`define SMSPI_AW             17
`define SMSPI_DEPTH          131072
`define SMSPI_ADDR_ZERO      17'h0_0000
`define SMSPI_ADDR_ONE       17'h0_0001
// Serial framing
`define SMSPI_BIT_LAST       3'h7
`define SMSPI_BIT_ZERO       3'h0
`define SMSPI_BIT_ONE        3'h1
`define SMSPI_ADDR_LAST      2'h2
`define SMSPI_ACNT_ZERO      2'h0
`define SMSPI_ACNT_ONE       2'h1
`define SMSPI_BYTE_ZERO      8'h00
// Block protect selections
`define SMSPI_PROT_NONE      2'h0
`define SMSPI_PROT_QUARTER   2'h1
`define SMSPI_PROT_HALF      2'h2
`define SMSPI_QUARTER_TOP    2'h3
`endif

// ===== core/smspi_port.v
`timescale 1ns/100ps
`include "smspi_defs.vh"

module smspi_port (
  input  wire       ref_clk,     // System clock
  input  wire       resetn,      // Synchronous reset, active low
  input  wire       cs_n,        // Chip select pin
  input  wire       sck,         // Serial clock pin
  input  wire       si,          // Serial data in pin
  input  wire       hold_n,      // Pause pin
  input  wire       wp_n,        // Write protect pin
  output reg        so_out,      // Serial data out level
  output reg        so_oe,       // Serial out drive enable
  output reg  [7:0] status_byte, // Status byte
  output reg        sleep_mode,  // Sleep entered
  output reg        clk_mode3    // Mode 3 detected at last select fall
);

  ////////////////////////////////////////////////////////////////////////////
  // States, one-hot
  localparam [4:0] ST_IDLE = 5'h01; // Select high
  localparam [4:0] ST_OPC  = 5'h02; // Taking opcode
  localparam [4:0] ST_ADDR = 5'h04; // Taking address
  localparam [4:0] ST_DATA = 5'h08; // Data phase
  localparam [4:0] ST_DONE = 5'h10; // Ignore until select rises

  // Protection decode for one address
  function prot_hit;
    input [`SMSPI_AW-1:0] a;
    input [1:0]           sel;
    begin
      case (sel)
        `SMSPI_PROT_NONE:    prot_hit = 1'b0;
        `SMSPI_PROT_QUARTER: prot_hit = (a[`SMSPI_AW-1:`SMSPI_AW-2] == `SMSPI_QUARTER_TOP);
        `SMSPI_PROT_HALF:    prot_hit = a[`SMSPI_AW-1];
        default:             prot_hit = 1'b1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge history
  reg [1:0]           cs_sy;         // Select sync chain
  reg [1:0]           sck_sy;        // Clock sync chain
  reg [1:0]           si_sy;         // Data sync chain
  reg [1:0]           hold_sy;       // Pause sync chain
  reg [1:0]           wp_sy;         // Protect sync chain
  reg                 sck_prev;      // Last synced clock level
  reg                 cs_q;          // Select as seen, frozen by pause
  reg [4:0]           state;         // Control state
  reg [2:0]           bit_cnt;       // Bit in byte
  reg [1:0]           addr_cnt;      // Address byte count
  reg [6:0]           in_sh;         // Input shifter
  reg [7:0]           opcode;        // Latched opcode
  reg [`SMSPI_AW-1:0] addr;          // Address counter
  reg [7:0]           out_sh;        // Output shifter
  reg [7:0]           out_buf;       // Next byte to send
  reg                 out_load;      // Buffer awaiting first fall
  reg                 rd_drive;      // Read data on the line
  reg [7:0]           mem [0:`SMSPI_DEPTH-1]; // Storage array

  always @(posedge ref_clk) begin
    cs_sy   <= {cs_sy[0], cs_n};
    sck_sy  <= {sck_sy[0], sck};
    si_sy   <= {si_sy[0], si};
    hold_sy <= {hold_sy[0], hold_n};
    wp_sy   <= {wp_sy[0], wp_n};
  end

  // Qualified events
  wire                 paused   = ~hold_sy[1];
  wire                 sck_rise = ~paused & sck_sy[1] & ~sck_prev;
  wire                 sck_fall = ~paused & ~sck_sy[1] & sck_prev;
  wire                 cs_fall  = ~paused & cs_q & ~cs_sy[1];
  wire                 cs_rise  = ~paused & ~cs_q & cs_sy[1];
  wire [7:0]           in_byte  = {in_sh, si_sy[1]};
  wire                 byte_end = sck_rise & (bit_cnt == `SMSPI_BIT_LAST);
  wire [`SMSPI_AW-1:0] addr_nx  = {addr[`SMSPI_AW-2:0], si_sy[1]};
  wire                 st_wr_ok = status_byte[`SMSPI_ST_LATCH] & (~status_byte[`SMSPI_ST_LOCK] | wp_sy[1]);
  wire                 mem_wr_ok = status_byte[`SMSPI_ST_LATCH] &
                                   ~prot_hit(addr, status_byte[`SMSPI_ST_PSEL_HI:`SMSPI_ST_PSEL_LO]);

  ////////////////////////////////////////////////////////////////////////////
  // Storage writes
  always @(posedge ref_clk) begin
    if (resetn && ~cs_q && byte_end && (state == ST_DATA) && (opcode == `SMSPI_OP_DATA_WRITE) && mem_wr_ok) begin
      mem[addr] <= in_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always @(posedge ref_clk) begin
    if (!resetn) begin
      sck_prev    <= 1'b0;
      cs_q        <= 1'b1;
      state       <= ST_IDLE;
      bit_cnt     <= `SMSPI_BIT_ZERO;
      addr_cnt    <= `SMSPI_ACNT_ZERO;
      in_sh       <= 7'h00;
      opcode      <= `SMSPI_BYTE_ZERO;
      addr        <= `SMSPI_ADDR_ZERO;
      out_sh      <= `SMSPI_BYTE_ZERO;
      out_buf     <= `SMSPI_BYTE_ZERO;
      out_load    <= 1'b0;
      rd_drive    <= 1'b0;
      so_out      <= 1'b0;
      so_oe       <= 1'b0;
      status_byte <= `SMSPI_ST_RESET;
      sleep_mode  <= 1'b0;
      clk_mode3   <= 1'b0;
    end else begin
      sck_prev <= sck_sy[1];
      if (!paused) begin
        cs_q <= cs_sy[1];
      end
      if (cs_rise || (cs_q && !cs_fall)) begin
        state    <= ST_IDLE;
        rd_drive <= 1'b0;
        out_load <= 1'b0;
      end else if (cs_fall) begin
        clk_mode3 <= sck_sy[1];
        state     <= ST_OPC;
        bit_cnt   <= `SMSPI_BIT_ZERO;
        addr_cnt  <= `SMSPI_ACNT_ZERO;
      end else begin
        if (sck_rise) begin
          in_sh   <= in_byte[6:0];
          bit_cnt <= bit_cnt + `SMSPI_BIT_ONE;
          if (state == ST_ADDR) begin
            addr <= addr_nx;
          end
        end
        if (byte_end) begin
          case (state)
            ST_OPC: begin
              opcode <= in_byte;
              state  <= ST_DONE;
              if (sleep_mode) begin
                if (in_byte == `SMSPI_OP_WAKE) begin
                  sleep_mode <= 1'b0;
                end
              end else begin
                case (in_byte)
                  `SMSPI_OP_SET_LATCH: status_byte[`SMSPI_ST_LATCH] <= 1'b1;
                  `SMSPI_OP_CLR_LATCH: status_byte[`SMSPI_ST_LATCH] <= 1'b0;
                  `SMSPI_OP_STAT_READ: begin
                    out_buf  <= status_byte;
                    out_load <= 1'b1;
                    state    <= ST_DATA;
                  end
                  `SMSPI_OP_STAT_WRITE: state <= ST_DATA;
                  `SMSPI_OP_DATA_READ: state <= ST_ADDR;
                  `SMSPI_OP_DATA_WRITE: state <= ST_ADDR;
                  `SMSPI_OP_SLEEP: sleep_mode <= 1'b1;
                  default: state <= ST_DONE;
                endcase
              end
            end
            ST_ADDR: begin
              addr_cnt <= addr_cnt + `SMSPI_ACNT_ONE;
              if (addr_cnt == `SMSPI_ADDR_LAST) begin
                state <= ST_DATA;
                if (opcode == `SMSPI_OP_DATA_READ) begin
                  out_buf  <= mem[addr_nx];
                  out_load <= 1'b1;
                  addr     <= addr_nx + `SMSPI_ADDR_ONE;
                end
              end
            end
            ST_DATA: begin
              case (opcode)
                `SMSPI_OP_STAT_WRITE: begin
                  if (st_wr_ok) begin
                    status_byte <= (in_byte & `SMSPI_ST_WMASK) | (status_byte & ~`SMSPI_ST_WMASK);
                  end
                  state <= ST_DONE;
                end
                `SMSPI_OP_STAT_READ: begin
                  out_buf  <= status_byte;
                  out_load <= 1'b1;
                end
                `SMSPI_OP_DATA_READ: begin
                  out_buf  <= mem[addr];
                  out_load <= 1'b1;
                  addr     <= addr + `SMSPI_ADDR_ONE;
                end
                `SMSPI_OP_DATA_WRITE: begin
                  addr <= addr + `SMSPI_ADDR_ONE;
                end
                default: state <= ST_DONE;
              endcase
            end
            default: state <= state;
          endcase
        end
        if (sck_fall && (state == ST_DATA)) begin
          if (out_load) begin
            so_out   <= out_buf[7];
            out_sh   <= {out_buf[6:0], 1'b0};
            out_load <= 1'b0;
            rd_drive <= 1'b1;
          end else begin
            so_out <= out_sh[7];
            out_sh <= {out_sh[6:0], 1'b0};
          end
        end
      end
      // Drive only read data, not paused
      so_oe <= rd_drive & ~cs_q & hold_sy[1] & ~cs_rise & ~(cs_q & !cs_fall);
    end
  end

endmodule // smspi_port

// ===== testbench/smspi_chk_sva.sv
`timescale 1ns/100ps
// Pin-level checks on the command port
module smspi_chk (
  input wire       ref_clk,
  input wire       resetn,
  input wire       cs_n,
  input wire       sck,
  input wire       si,
  input wire       hold_n,
  input wire       wp_n,
  input wire       so_out,
  input wire       so_oe,
  input wire [7:0] status_byte,
  input wire       sleep_mode,
  input wire       clk_mode3
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////
  a_idle_quiet: assert property (cs_n [*6] |-> !so_oe && $stable(status_byte))
    else $error("output driven or status moved while deselected");
  a_pause_quiet: assert property (!hold_n [*6] |-> !so_oe)
    else $error("output driven while paused");
  a_out_on_fall: assert property ((sck && !cs_n) [*6] |=> $stable(so_out))
    else $error("serial out moved without a clock fall");
  a_pin_locks: assert property ((!wp_n [*4] ##0 status_byte[7]) |=> $stable(status_byte[7:2]))
    else $error("locked status changed with protect pin low");
  a_latch_gates: assert property ($changed({status_byte[7:2], status_byte[0]}) |-> $past(status_byte[1]))
    else $error("status written with latch clear");
  // Mode 3 frames drop the clock four cycles after select falls, so only three stable cycles are asked for
  a_mode_taken: assert property (($fell(cs_n) && hold_n) ##1 (!cs_n && hold_n && $stable(sck)) [*3]
    |-> clk_mode3 == sck)
    else $error("clock mode not taken at select fall");
  a_sleep_quiet: assert property (sleep_mode |-> !so_oe)
    else $error("output driven while asleep");
  a_sleep_framed: assert property ($changed(sleep_mode) |-> !$past(cs_n, 4))
    else $error("sleep state moved outside a frame");
endmodule // smspi_chk

bind smspi_port smspi_chk u_chk (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
  .hold_n(hold_n), .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .status_byte(status_byte),
  .sleep_mode(sleep_mode), .clk_mode3(clk_mode3));

// ===== testbench/smspi_host.sv
`timescale 1ns/100ps
// Host controller model driving the port pins at ref_clk falls
module smspi_host (
  input  wire       ref_clk,
  input  wire       so_out,
  input  wire       so_oe,
  output reg        cs_n   = 1'b1,
  output reg        sck    = 1'b0,
  output reg        si     = 1'b0,
  output reg        hold_n = 1'b1
);
  reg       oe_seen = 1'b0;                // Any drive seen in frame
  reg       held    = 1'b0;                // Drive level during pause
  reg       last    = 1'b0;                // Last level read
  reg [7:0] rx      = 8'h00;               // Byte shifted in
  integer   i;
  wire      so_w    = so_oe ? so_out : ~last; // Released line shows no stale level
  // Clock parked at mode level before select falls
  task open_frame(input reg m3);
    begin
      sck = m3;
      repeat (4) @(negedge ref_clk);
      cs_n = 1'b0;
      oe_seen = 1'b0;
      repeat (4) @(negedge ref_clk);
    end
  endtask
  // Whole bytes, MSB first, 80 ns clock period
  task xfer(input reg [7:0] tx);
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sck = 1'b0;
        si = tx[i];
        repeat (4) @(negedge ref_clk);
        sck = 1'b1;
        repeat (4) @(negedge ref_clk);
        rx[i] = so_w;
        last = so_w;
        oe_seen = oe_seen | so_oe;
      end
    end
  endtask
  task close_frame(input reg m3);
    begin
      sck = m3;
      repeat (4) @(negedge ref_clk);
      cs_n = 1'b1;
      repeat (8) @(negedge ref_clk);
    end
  endtask
  // Pause inside a frame, with clock pulses to be ignored
  task pause;
    begin
      hold_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      repeat (2) begin
        sck = 1'b0;
        repeat (4) @(negedge ref_clk);
        sck = 1'b1;
        repeat (4) @(negedge ref_clk);
      end
      held = so_oe;
      hold_n = 1'b1;
      repeat (6) @(negedge ref_clk);
    end
  endtask
endmodule // smspi_host

// ===== testbench/smspi_port_tb_top.sv
`timescale 1ns/100ps
`include "smspi_defs.vh"
// Self-checking bench for the command port
module smspi_port_tb_top;
  reg        ref_clk = 1'b0;
  reg        resetn  = 1'b0;
  reg        wp_n    = 1'b1;
  reg        mode3   = 1'b0;
  reg  [7:0] r0;
  reg  [7:0] r1;
  integer    miscompares = 0;
  integer    comparisons = 0;
  wire       cs_n, sck, si, hold_n, so_out, so_oe, sleep_mode, clk_mode3;
  wire [7:0] status_byte;
  initial forever #5 ref_clk = ~ref_clk;
  smspi_port DUT (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n),
    .wp_n(wp_n), .so_out(so_out), .so_oe(so_oe), .status_byte(status_byte), .sleep_mode(sleep_mode),
    .clk_mode3(clk_mode3));
  smspi_host host (.ref_clk(ref_clk), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si),
    .hold_n(hold_n));
  ////////////////////////////////////////
  task chk(input string nm, input reg [7:0] exp, input reg [7:0] got);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Opcode and optional data byte; reply lands in r0
  task frame(input reg [7:0] op, input reg [7:0] d, input reg more);
    begin
      host.open_frame(mode3);
      host.xfer(op);
      if (more) begin
        host.xfer(d);
        r0 = host.rx;
      end
      host.close_frame(mode3);
    end
  endtask
  // Opcode, three address bytes, two data bytes; optional pause between
  task mem(input reg [7:0] op, input reg [23:0] a, input reg [7:0] d0, input reg [7:0] d1, input reg p);
    begin
      host.open_frame(mode3);
      host.xfer(op);
      host.xfer(a[23:16]);
      host.xfer(a[15:8]);
      host.xfer(a[7:0]);
      host.xfer(d0);
      r0 = host.rx;
      if (p) host.pause;
      host.xfer(d1);
      r1 = host.rx;
      host.close_frame(mode3);
    end
  endtask
  ////////////////////////////////////////
  task t_latch;
    begin
      frame(`SMSPI_OP_SET_LATCH, 8'h00, 1'b0);
      frame(`SMSPI_OP_STAT_READ, 8'h00, 1'b1);
      chk("status read", 8'h02, r0);
      frame(`SMSPI_OP_CLR_LATCH, 8'h00, 1'b0);
      chk("cleared status", 8'h00, status_byte);
      frame(`SMSPI_OP_SET_LATCH, `SMSPI_OP_STAT_READ, 1'b1);
      chk("second op drive", 8'h00, {7'h00, host.oe_seen});
      chk("set status", 8'h02, status_byte);
      $display("test latch done");
    end
  endtask
  task t_data;
    begin
      mem(`SMSPI_OP_DATA_WRITE, 24'h01_FFFF, 8'hA5, 8'h3C, 1'b0);
      // Upper address byte differs from the write; only the low 17 bits count
      mem(`SMSPI_OP_DATA_READ, 24'hFF_FFFF, 8'h00, 8'h00, 1'b1);
      chk("top byte", 8'hA5, r0);
      chk("wrapped byte", 8'h3C, r1);
      chk("paused drive", 8'h00, {7'h00, host.held});
      $display("test data done");
    end
  endtask
  task t_prot;
    begin
      frame(`SMSPI_OP_STAT_WRITE, 8'h84, 1'b1);
      chk("locked status", 8'h86, status_byte);
      mem(`SMSPI_OP_DATA_WRITE, 24'h01_FFFF, 8'h11, 8'h66, 1'b0);
      wp_n = 1'b0;
      frame(`SMSPI_OP_STAT_WRITE, 8'h00, 1'b1);
      chk("pin refused", 8'h86, status_byte);
      wp_n = 1'b1;
      frame(`SMSPI_OP_STAT_WRITE, 8'h00, 1'b1);
      chk("pin allowed", 8'h02, status_byte);
      // Latch cleared: this unprotected write must be refused as well
      frame(`SMSPI_OP_CLR_LATCH, 8'h00, 1'b0);
      mem(`SMSPI_OP_DATA_WRITE, 24'h01_FFFF, 8'h99, 8'h77, 1'b0);
      mem(`SMSPI_OP_DATA_READ, 24'h01_FFFF, 8'h00, 8'h00, 1'b0);
      chk("upper quarter", 8'hA5, r0);
      chk("lower area", 8'h66, r1);
      $display("test protect done");
    end
  endtask
  task t_sleep;
    begin
      mode3 = 1'b1;
      frame(`SMSPI_OP_SLEEP, 8'h00, 1'b0);
      chk("mode 3", 8'h01, {7'h00, clk_mode3});
      chk("asleep", 8'h01, {7'h00, sleep_mode});
      mem(`SMSPI_OP_DATA_READ, 24'h01_FFFF, 8'h00, 8'h00, 1'b0);
      chk("asleep drive", 8'h00, {7'h00, host.oe_seen});
      frame(`SMSPI_OP_WAKE, 8'h00, 1'b0);
      chk("awake", 8'h00, {7'h00, sleep_mode});
      mode3 = 1'b0;
      frame(8'hFF, `SMSPI_OP_STAT_READ, 1'b1);
      chk("unknown drive", 8'h00, {7'h00, host.oe_seen});
      chk("mode 0", 8'h00, {7'h00, clk_mode3});
      $display("test sleep done");
    end
  endtask
  ////////////////////////////////////////
  task close_out;
    begin
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Main sequence after reset
  initial begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
    t_latch;
    t_data;
    t_prot;
    t_sleep;
    close_out;
  end
  // Watchdog, about five times the expected run
  initial begin
    #200000;
    miscompares = miscompares + 1;
    close_out;
  end
endmodule // smspi_port_tb_top
